// ==== design/at8_pkg.sv ====
// Purpose: shared constants for the 8-bit timer register block
// Assumes: register indices are byte addresses divided by four
// Notes:   counter, compare b indices are local choices
package at8_pkg;

	// register indices, byte address is index times four
	localparam logic [7:0] IDX_IRQ_FLAGS = 8'h37;
	localparam logic [7:0] IDX_IRQ_MASK  = 8'h70;
	localparam logic [7:0] IDX_CTRL_B    = 8'hB1;
	localparam logic [7:0] IDX_CMP_A     = 8'hB3;
	localparam logic [7:0] IDX_ASYNC     = 8'hB6;
	localparam logic [7:0] IDX_COUNTER   = 8'hC0;
	localparam logic [7:0] IDX_CMP_B     = 8'hC1;

	// control b fields
	localparam int CTLB_FORCE_A = 7;
	localparam int CTLB_FORCE_B = 6;
	localparam int CTLB_WAVE_HI = 3;
	localparam int CTLB_PRESC   = 0;

	// flag and mask fields
	localparam int FLAG_OVF     = 0;
	localparam int FLAG_MATCH_A = 1;
	localparam int FLAG_MATCH_B = 2;

	// async status fields
	localparam int AS_EXT_EN    = 6;
	localparam int AS_ASYNC_SEL = 5;
	localparam int AS_BUSY_CNT  = 4;
	localparam int AS_BUSY_CMPA = 3;
	localparam int AS_BUSY_CMPB = 2;
	localparam int AS_BUSY_CTLA = 1;
	localparam int AS_BUSY_CTLB = 0;

	// reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// wave modes
	localparam logic [2:0] WM_NORMAL    = 3'h0;
	localparam logic [2:0] WM_PC_FULL   = 3'h1;
	localparam logic [2:0] WM_CTC       = 3'h2;
	localparam logic [2:0] WM_FAST_FULL = 3'h3;
	localparam logic [2:0] WM_PC_CMPA   = 3'h5;
	localparam logic [2:0] WM_FAST_CMPA = 3'h7;

	// output modes
	localparam logic [1:0] OM_OFF    = 2'h0;
	localparam logic [1:0] OM_TOGGLE = 2'h1;
	localparam logic [1:0] OM_CLEAR  = 2'h2;
	localparam logic [1:0] OM_SET    = 2'h3;

	// counter limits
	localparam logic [7:0] CNT_MAX    = 8'hFF;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;

	// prescaler
	localparam int PRESC_W = 10;

	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// clock
	localparam int CLK_PERIOD_NS = 4;

	// divider width for each clock select code: 1, 8, 32, 64, 128, 256, 1024
	function automatic logic [3:0] at8_presc_bits(input logic [2:0] sel);
		unique case (sel)
			3'h2:    at8_presc_bits = 4'h3;
			3'h3:    at8_presc_bits = 4'h5;
			3'h4:    at8_presc_bits = 4'h6;
			3'h5:    at8_presc_bits = 4'h7;
			3'h6:    at8_presc_bits = 4'h8;
			3'h7:    at8_presc_bits = 4'hA;
			default: at8_presc_bits = 4'h0;
		endcase
	endfunction : at8_presc_bits

endpackage : at8_pkg

// ==== design/at8_tick_if.sv ====
// Purpose: carries clock source ticks to the prescaler and counter ticks back
// Assumes: single aclk domain
// Notes:   count_tick is combinational
`timescale 1ns/1ps
interface at8_tick_if;
	logic       source_tick;
	logic [2:0] prescale_select;
	logic       count_tick;

	modport core  (output source_tick, output prescale_select, input count_tick);
	modport presc (input source_tick, input prescale_select, output count_tick);
endinterface : at8_tick_if

// ==== design/at8_prescaler.sv ====
// Purpose: divides the prescaler source clock ticks by the selected ratio
// Assumes: source_tick is a one-cycle pulse per source clock edge
// Notes:   divider runs freely; select 0 gives no ticks
`timescale 1ns/1ps
module at8_prescaler (
	input wire logic aclk,
	input wire logic aresetn,
	at8_tick_if.presc tick
);
	import at8_pkg::*;

	typedef struct packed {
		logic [PRESC_W-1:0] div;
	} at8_presc_state_type;

	at8_presc_state_type s_q;
	at8_presc_state_type s_d;
	logic [PRESC_W-1:0]  mask;

	// low bits that must all be set for a divided tick
	assign mask = (PRESC_W'(1) << at8_presc_bits(tick.prescale_select)) - PRESC_W'(1);

	// clock select: stop, undivided or divided tick
	assign tick.count_tick = tick.source_tick && (tick.prescale_select != 3'h0)
		&& ((s_q.div & mask) == mask);

	// divider advances on each source tick
	always_comb begin
		s_d = s_q;
		if (tick.source_tick) begin
			s_d.div = s_q.div + PRESC_W'(1);
		end
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : at8_prescaler

// ==== design/at8_timer.sv ====
// Purpose: 8-bit timer with compare channels and async update handshake
// Assumes: AXI4-Lite slave, one aclk domain, timer_osc_pin is sampled
// Notes:   async mode counts rising edges of the synchronised pin
//
// Contract
// - force bit applies match action to output
// - force bits ignored in PWM modes
// - forced match sets no flag, no clear
// - force bits always read zero
// - control b bits 5:4 read zero
// - clock select stops, passes or divides
// - counter readable and writable live
// - counter write blocks next tick's matches
// - compare registers matched continuously with count
// - flags set on matches and overflow
// - phase-correct PWM overflow flag at bottom reversal
// - vector execution clears its flag
// - writing one clears flag, zero keeps
// - request needs mask, flag, global enable
// - external clock buffer versus crystal enable
// - async select picks counter clock source
// - async writes set busy until transfer
// - async status bit 7 reads zero
// - wave mode selects sequence and top
// - non-PWM output modes toggle, clear, set
// - control writes busy too in async
// - counter reads live, others read temporaries
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module at8_timer #(
	parameter int ADDR_W = 12
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              timer_osc_pin,
	input  wire logic [1:0]        wave_mode_lower_bits,
	input  wire logic [1:0]        output_mode_a,
	input  wire logic [1:0]        output_mode_b,
	input  wire logic              control_a_write,
	input  wire logic              global_irq_enable,
	input  wire logic [2:0]        irq_vector_ack,
	output logic [2:0]             irq_request,
	output logic                   wave_out_a,
	output logic                   wave_out_a_oe,
	output logic                   wave_out_b,
	output logic                   wave_out_b_oe,
	output logic                   osc_buffer_enable,
	output logic                   crystal_osc_enable
);
	import at8_pkg::*;

	typedef struct packed {
		logic       aw_got;
		logic [7:0] aw_idx;
		logic       w_got;
		logic [7:0] wdata;
		logic       wlane;
		logic       bvalid;
		logic [1:0] bresp;
		logic       rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		logic       osc_s1;
		logic       osc_s2;
		logic       osc_s3;
		logic [2:0] irq_mask;
		logic [2:0] irq_flags;
		logic       ext_en;
		logic       async_sel;
		logic [4:0] busy;
		logic       wave_hi_tmp;
		logic [2:0] presc_tmp;
		logic       wave_hi;
		logic [2:0] presc;
		logic [7:0] cmpa_tmp;
		logic [7:0] cmpa;
		logic [7:0] cmpb_tmp;
		logic [7:0] cmpb;
		logic [7:0] cnt;
		logic [7:0] cnt_tmp;
		logic       cnt_pend;
		logic       block_match;
		logic       count_down;
		logic       wave_a;
		logic       wave_b;
	} at8_state_type;

	at8_state_type s_q;
	at8_state_type s_d;
	at8_tick_if    tick ();

	logic [2:0] wave_mode;
	logic       pwm;
	logic       phase_pwm;
	logic [7:0] top;
	logic       tick_ok;
	logic       match_a;
	logic       match_b;
	logic       at_top;
	logic       osc_rise;
	logic       wr_fire;
	logic       wr_on;
	logic [7:0] ar_idx;
	logic [2:0] flag_set;

	// true for every register index this block answers
	function automatic logic at8_known(input logic [7:0] idx);
		at8_known = (idx == IDX_IRQ_FLAGS) || (idx == IDX_IRQ_MASK) || (idx == IDX_CTRL_B)
			|| (idx == IDX_CMP_A) || (idx == IDX_ASYNC) || (idx == IDX_COUNTER)
			|| (idx == IDX_CMP_B);
	endfunction : at8_known

	// output level after a compare event for one channel
	function automatic logic at8_wave_next(input logic cur, input logic [1:0] om,
		input logic [2:0] wm, input logic hit, input logic bottom, input logic down,
		input logic may_toggle);
		logic is_pwm;
		logic is_phase;
		is_pwm   = wm[0];
		is_phase = wm[0] && !wm[1];
		at8_wave_next = cur;
		if (!is_pwm) begin
			if (hit) begin
				unique case (om)
					OM_TOGGLE: at8_wave_next = !cur;
					OM_CLEAR:  at8_wave_next = 1'b0;
					OM_SET:    at8_wave_next = 1'b1;
					OM_OFF:    at8_wave_next = cur;
				endcase
			end
		end else if (om == OM_TOGGLE) begin
			if (hit && may_toggle) begin
				at8_wave_next = !cur;
			end
		end else if (om != OM_OFF) begin
			if (is_phase) begin
				if (hit) begin
					at8_wave_next = (om == OM_CLEAR) ? down : !down;
				end
			end else if (hit) begin
				at8_wave_next = (om == OM_SET);
			end else if (bottom) begin
				at8_wave_next = (om == OM_CLEAR);
			end
		end
	endfunction : at8_wave_next

	// mode decode
	assign wave_mode = {s_q.wave_hi, wave_mode_lower_bits};
	assign pwm       = wave_mode[0];
	assign phase_pwm = wave_mode[0] && !wave_mode[1];
	assign top       = ((wave_mode == WM_CTC) || (wave_mode == WM_PC_CMPA)
		|| (wave_mode == WM_FAST_CMPA)) ? s_q.cmpa : CNT_MAX;
	assign at_top    = (s_q.cnt == top);

	// timer clock source, undivided
	assign osc_rise              = s_q.osc_s2 && !s_q.osc_s3;
	assign tick.source_tick      = s_q.async_sel ? osc_rise : 1'b1;
	assign tick.prescale_select  = s_q.presc;
	assign tick_ok               = tick.count_tick && !s_q.cnt_pend;

	// continuous compare, suppressed right after a counter write
	assign match_a = tick_ok && (s_q.cnt == s_q.cmpa) && !s_q.block_match;
	assign match_b = tick_ok && (s_q.cnt == s_q.cmpb) && !s_q.block_match;

	// bus decode
	assign wr_fire = s_q.aw_got && s_q.w_got;
	assign wr_on   = wr_fire && s_q.wlane && at8_known(s_q.aw_idx);
	assign ar_idx  = s_axi_araddr[9:2];

	at8_prescaler u_presc (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (tick.presc)
	);

	// next state
	always_comb begin
		s_d = s_q;
		flag_set = 3'h0;

		// two-stage pin synchroniser plus edge history
		s_d.osc_s1 = timer_osc_pin;
		s_d.osc_s2 = s_q.osc_s1;
		s_d.osc_s3 = s_q.osc_s2;

		// write address and data, taken in either order
		if (s_axi_awvalid && !s_q.aw_got && !s_q.bvalid) begin
			s_d.aw_got = 1'b1;
			s_d.aw_idx = s_axi_awaddr[9:2];
		end
		if (s_axi_wvalid && !s_q.w_got && !s_q.bvalid) begin
			s_d.w_got = 1'b1;
			s_d.wdata = s_axi_wdata[7:0];
			s_d.wlane = s_axi_wstrb[0];
		end
		if (wr_fire) begin
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = at8_known(s_q.aw_idx) ? RESP_OKAY : RESP_DECERR;
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end

		// read answer one cycle after the address
		if (s_axi_arvalid && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = at8_known(ar_idx) ? RESP_OKAY : RESP_DECERR;
			unique case (ar_idx)
				IDX_IRQ_FLAGS: s_d.rdata = {5'h00, s_q.irq_flags};
				IDX_IRQ_MASK:  s_d.rdata = {5'h00, s_q.irq_mask};
				IDX_CTRL_B:    s_d.rdata = {4'h0, s_q.wave_hi_tmp, s_q.presc_tmp};
				IDX_CMP_A:     s_d.rdata = s_q.cmpa_tmp;
				IDX_CMP_B:     s_d.rdata = s_q.cmpb_tmp;
				IDX_COUNTER:   s_d.rdata = s_q.cnt;
				IDX_ASYNC:     s_d.rdata = {1'b0, s_q.ext_en, s_q.async_sel, s_q.busy};
				default:       s_d.rdata = 8'h00;
			endcase
		end else if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end

		// temporaries move into the working registers: at once when
		// synchronous, on the next source tick when asynchronous
		if (!s_q.async_sel || tick.source_tick) begin
			s_d.wave_hi = s_q.wave_hi_tmp;
			s_d.presc   = s_q.presc_tmp;
			s_d.cmpa    = s_q.cmpa_tmp;
			s_d.cmpb    = s_q.cmpb_tmp;
			s_d.busy    = 5'h00;
		end

		// counter sequence on each selected timer tick
		if (tick_ok) begin
			if (s_q.block_match) begin
				s_d.block_match = 1'b0;
			end
			if (phase_pwm) begin
				if (!s_q.count_down && at_top) begin
					s_d.count_down = 1'b1;
					s_d.cnt        = s_q.cnt - 8'h01;
				end else if (s_q.count_down && (s_q.cnt == CNT_BOTTOM)) begin
					s_d.count_down = 1'b0;
					s_d.cnt        = s_q.cnt + 8'h01;
					flag_set[FLAG_OVF] = 1'b1;
				end else begin
					s_d.cnt = s_q.count_down ? s_q.cnt - 8'h01 : s_q.cnt + 8'h01;
				end
			end else begin
				s_d.count_down = 1'b0;
				s_d.cnt        = at_top ? CNT_BOTTOM : s_q.cnt + 8'h01;
				if ((wave_mode == WM_FAST_CMPA) ? at_top : (s_q.cnt == CNT_MAX)) begin
					flag_set[FLAG_OVF] = 1'b1;
				end
			end
		end

		// compare flags and waveform outputs
		flag_set[FLAG_MATCH_A] = match_a;
		flag_set[FLAG_MATCH_B] = match_b;
		s_d.wave_a = at8_wave_next(s_q.wave_a, output_mode_a, wave_mode, match_a,
			tick_ok && at_top, s_q.count_down, s_q.wave_hi);
		s_d.wave_b = at8_wave_next(s_q.wave_b, output_mode_b, wave_mode, match_b,
			tick_ok && at_top, s_q.count_down, 1'b0);

		// first control register written elsewhere, busy flagged here
		if (control_a_write && s_q.async_sel) begin
			s_d.busy[AS_BUSY_CTLA] = 1'b1;
		end

		// pending counter load lands on the source tick
		if (s_q.cnt_pend && tick.source_tick) begin
			s_d.cnt         = s_q.cnt_tmp;
			s_d.cnt_pend    = 1'b0;
			s_d.block_match = 1'b1;
		end

		// vector execution clears its flag, a same-cycle event wins
		s_d.irq_flags = (s_d.irq_flags & ~irq_vector_ack) | flag_set;

		// register writes
		if (wr_on) begin
			unique case (s_q.aw_idx)
				IDX_IRQ_FLAGS: begin
					s_d.irq_flags = s_d.irq_flags & ~(s_q.wdata[2:0] & ~flag_set);
				end
				IDX_IRQ_MASK: begin
					s_d.irq_mask = s_q.wdata[2:0];
				end
				IDX_CTRL_B: begin
					s_d.wave_hi_tmp = s_q.wdata[CTLB_WAVE_HI];
					s_d.presc_tmp   = s_q.wdata[CTLB_PRESC +: 3];
					if (s_q.async_sel) begin
						s_d.busy[AS_BUSY_CTLB] = 1'b1;
					end
					// forced match: output only, no flag, no counter clear
					if (!pwm && s_q.wdata[CTLB_FORCE_A]) begin
						s_d.wave_a = at8_wave_next(s_q.wave_a, output_mode_a, wave_mode,
							1'b1, 1'b0, 1'b0, 1'b0);
					end
					if (!pwm && s_q.wdata[CTLB_FORCE_B]) begin
						s_d.wave_b = at8_wave_next(s_q.wave_b, output_mode_b, wave_mode,
							1'b1, 1'b0, 1'b0, 1'b0);
					end
				end
				IDX_CMP_A: begin
					s_d.cmpa_tmp = s_q.wdata;
					if (s_q.async_sel) begin
						s_d.busy[AS_BUSY_CMPA] = 1'b1;
					end
				end
				IDX_CMP_B: begin
					s_d.cmpb_tmp = s_q.wdata;
					if (s_q.async_sel) begin
						s_d.busy[AS_BUSY_CMPB] = 1'b1;
					end
				end
				IDX_COUNTER: begin
					if (s_q.async_sel) begin
						s_d.cnt_tmp           = s_q.wdata;
						s_d.cnt_pend          = 1'b1;
						s_d.busy[AS_BUSY_CNT] = 1'b1;
					end else begin
						s_d.cnt         = s_q.wdata;
						s_d.block_match = 1'b1;
					end
				end
				IDX_ASYNC: begin
					s_d.ext_en    = s_q.wdata[AS_EXT_EN];
					s_d.async_sel = s_q.wdata[AS_ASYNC_SEL];
				end
				default: begin
					s_d.irq_mask = s_q.irq_mask;
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// bus handshakes
	assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
	assign s_axi_wready  = !s_q.w_got && !s_q.bvalid;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rresp   = s_q.rresp;
	assign s_axi_rdata   = {24'h000000, s_q.rdata};

	// interrupt requests
	assign irq_request = s_q.irq_mask & s_q.irq_flags & {3{global_irq_enable}};

	// oscillator pin front end
	assign osc_buffer_enable  = s_q.ext_en && s_q.async_sel;
	assign crystal_osc_enable = !s_q.ext_en;

	// waveform pins, disconnected in off and reserved output modes
	assign wave_out_a    = s_q.wave_a;
	assign wave_out_b    = s_q.wave_b;
	assign wave_out_a_oe = (output_mode_a != OM_OFF)
		&& !(pwm && (output_mode_a == OM_TOGGLE) && !s_q.wave_hi);
	assign wave_out_b_oe = (output_mode_b != OM_OFF)
		&& !(pwm && (output_mode_b == OM_TOGGLE));
endmodule : at8_timer

// ==== testbench/at8_timer_monitor.sv ====
// Purpose: port-level checks on the 8-bit timer register block
// Assumes: one aclk domain, synchronous active-low reset
// Notes:   bound onto every timer instance below the module
`timescale 1ns/1ps
module at8_timer_monitor
	import at8_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [1:0]  output_mode_a,
	input wire logic [1:0]  output_mode_b,
	input wire logic        global_irq_enable,
	input wire logic [2:0]  irq_request,
	input wire logic        wave_out_a_oe,
	input wire logic        wave_out_b_oe,
	input wire logic        osc_buffer_enable,
	input wire logic        crystal_osc_enable
);
	default clocking mon_cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// interrupt gating and oscillator exclusivity
	a_irq_needs_global: assert property (irq_request != 3'h0 |-> global_irq_enable)
		else $error("interrupt request without global enable");
	a_osc_exclusive: assert property (osc_buffer_enable |-> !crystal_osc_enable)
		else $error("crystal running beside external clock buffer");
	// disconnected output mode releases the pin
	a_pin_a_released: assert property (output_mode_a == OM_OFF |-> !wave_out_a_oe)
		else $error("pin a driven while disconnected");
	a_pin_b_released: assert property (output_mode_b == OM_OFF |-> !wave_out_b_oe)
		else $error("pin b driven while disconnected");
	// bus answers stand and come on time
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	a_read_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data upper bits set");
endmodule : at8_timer_monitor

bind at8_timer at8_timer_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.output_mode_a(output_mode_a), .output_mode_b(output_mode_b),
	.global_irq_enable(global_irq_enable), .irq_request(irq_request),
	.wave_out_a_oe(wave_out_a_oe), .wave_out_b_oe(wave_out_b_oe),
	.osc_buffer_enable(osc_buffer_enable), .crystal_osc_enable(crystal_osc_enable));

// ==== testbench/at8_timer_tb_top.sv ====
// Purpose: register-level self-checking bench for the 8-bit timer
// Assumes: bready and rready held high, full write strobes
// Notes:   counter span checks allow a few ticks of prescaler phase
`timescale 1ns/1ps
module at8_timer_tb_top;
	import at8_pkg::*;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, timer_osc_pin, control_a_write, global_irq_enable;
	logic        wave_out_a, wave_out_a_oe, wave_out_b, wave_out_b_oe;
	logic        osc_buffer_enable, crystal_osc_enable;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp, wave_mode_lower_bits;
	logic [1:0]  output_mode_a, output_mode_b;
	logic [2:0]  irq_vector_ack, irq_request;
	int          fail_count, cmp_count;
	logic [7:0]  regs [7] = '{IDX_IRQ_FLAGS, IDX_IRQ_MASK, IDX_CTRL_B, IDX_CMP_A, IDX_ASYNC,
		IDX_COUNTER, IDX_CMP_B};
	logic [1:0]  fmode [4] = '{OM_SET, OM_TOGGLE, OM_SET, OM_CLEAR};
	logic        fexp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
	int          divs [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};

	at8_timer #(.ADDR_W(12)) DUT (.*);

	// free-running clock
	initial begin
		aclk = 1'b0;
		forever #(CLK_PERIOD_NS / 2) aclk = ~aclk;
	end

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic bus_wr(input logic [7:0] idx, input logic [7:0] val);
		logic pa, pw, ta, tw;
		pa = 1'b1;
		pw = 1'b1;
		s_axi_awaddr  <= {2'b00, idx, 2'b00};
		s_axi_wdata   <= {24'h0, val};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		while (pa || pw) begin
			@(negedge aclk);
			ta = pa && s_axi_awready;
			tw = pw && s_axi_wready;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
		end
		do @(negedge aclk); while (!s_axi_bvalid);
		last_resp = s_axi_bresp;
		@(posedge aclk);
	endtask : bus_wr

	task automatic bus_rd(input logic [7:0] idx);
		logic ta;
		s_axi_araddr  <= {2'b00, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axi_arready;
			@(posedge aclk);
		end while (!ta);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (!s_axi_rvalid);
		rd_data   = s_axi_rdata;
		last_resp = s_axi_rresp;
		@(posedge aclk);
	endtask : bus_rd

	task automatic expect_rd(input string what, input logic [7:0] idx, input logic [31:0] exp);
		bus_rd(idx);
		check(what, rd_data, exp);
	endtask : expect_rd

	// hang guard
	initial begin
		repeat (90000) @(posedge aclk);
		fail_count++;
		wrap_up();
	end

	// main sequence
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, timer_osc_pin} = 5'h0;
		{control_a_write, global_irq_enable, irq_vector_ack} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{wave_mode_lower_bits, output_mode_a, output_mode_b} = 6'h0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		foreach (regs[i]) expect_rd("reset value", regs[i], 32'h0);
		bus_rd(8'h01);
		check("unmapped read", last_resp, RESP_DECERR);
		bus_wr(8'h02, 8'hFF);
		check("unmapped write", last_resp, RESP_DECERR);
		bus_wr(IDX_CTRL_B, 8'hF8);
		expect_rd("control b", IDX_CTRL_B, 32'h08);
		bus_wr(IDX_IRQ_MASK, 8'hFF);
		expect_rd("mask", IDX_IRQ_MASK, 32'h07);
		bus_wr(IDX_IRQ_MASK, 8'h00);
		// forced matches in normal mode, both channels
		foreach (fmode[i]) begin
			output_mode_a <= fmode[i];
			output_mode_b <= fmode[i];
			bus_wr(IDX_CTRL_B, 8'hC0);
			check("pin a", wave_out_a, fexp[i]);
			check("pin b", wave_out_b, fexp[i]);
		end
		expect_rd("flags", IDX_IRQ_FLAGS, 32'h0);
		wave_mode_lower_bits <= 2'h1;
		output_mode_a <= OM_SET;
		bus_wr(IDX_CTRL_B, 8'h80);
		check("pin a", wave_out_a, 1'b0);
		wave_mode_lower_bits <= 2'h0;
		bus_wr(IDX_COUNTER, 8'h55);
		expect_rd("counter", IDX_COUNTER, 32'h55);
		// every clock select, timed run
		for (int c = 0; c < 8; c++) begin
			bus_wr(IDX_COUNTER, 8'h00);
			bus_wr(IDX_CTRL_B, 8'(c));
			repeat (c == 0 ? 400 : 40 * divs[c]) @(posedge aclk);
			bus_wr(IDX_CTRL_B, 8'h00);
			bus_rd(IDX_COUNTER);
			check("ticks", c == 0 ? rd_data : 32'(rd_data inside {[32'h26:32'h2C]}),
				c == 0 ? 32'h0 : 32'h1);
		end
		// matches, overflow, requests and clearing
		bus_wr(IDX_IRQ_FLAGS, 8'h07);
		bus_wr(IDX_CMP_A, 8'h05);
		bus_wr(IDX_CMP_B, 8'h06);
		bus_wr(IDX_COUNTER, 8'h00);
		bus_wr(IDX_IRQ_MASK, 8'h07);
		global_irq_enable <= 1'b1;
		bus_wr(IDX_CTRL_B, 8'h01);
		repeat (300) @(posedge aclk);
		bus_wr(IDX_CTRL_B, 8'h00);
		expect_rd("flags", IDX_IRQ_FLAGS, 32'h07);
		check("requests", irq_request, 3'h7);
		global_irq_enable <= 1'b0;
		@(negedge aclk);
		check("requests", irq_request, 3'h0);
		bus_wr(IDX_IRQ_FLAGS, 8'h02);
		expect_rd("flags", IDX_IRQ_FLAGS, 32'h05);
		bus_wr(IDX_IRQ_FLAGS, 8'h00);
		expect_rd("flags", IDX_IRQ_FLAGS, 32'h05);
		irq_vector_ack <= 3'h1;
		@(posedge aclk);
		irq_vector_ack <= 3'h0;
		expect_rd("flags", IDX_IRQ_FLAGS, 32'h04);
		bus_wr(IDX_IRQ_FLAGS, 8'h07);
		// counter write hides the first match
		bus_wr(IDX_CMP_A, 8'h20);
		bus_wr(IDX_COUNTER, 8'h20);
		bus_wr(IDX_CTRL_B, 8'h01);
		repeat (5) @(posedge aclk);
		bus_wr(IDX_CTRL_B, 8'h00);
		expect_rd("flags", IDX_IRQ_FLAGS, 32'h0);
		// clear-on-match folds the count at compare a
		wave_mode_lower_bits <= 2'h2;
		bus_wr(IDX_CMP_A, 8'h10);
		bus_wr(IDX_COUNTER, 8'h00);
		bus_wr(IDX_CTRL_B, 8'h01);
		repeat (60) @(posedge aclk);
		bus_wr(IDX_CTRL_B, 8'h00);
		bus_rd(IDX_COUNTER);
		check("ctc top", 32'(rd_data <= 32'h10), 32'h1);
		expect_rd("flags", IDX_IRQ_FLAGS, 32'h06);
		// phase correct: overflow only when turning at bottom
		wave_mode_lower_bits <= 2'h1;
		bus_wr(IDX_COUNTER, 8'h00);
		bus_wr(IDX_IRQ_FLAGS, 8'h07);
		bus_wr(IDX_CTRL_B, 8'h01);
		repeat (300) @(posedge aclk);
		expect_rd("flags", IDX_IRQ_FLAGS, 32'h06);
		repeat (300) @(posedge aclk);
		bus_wr(IDX_CTRL_B, 8'h00);
		expect_rd("flags", IDX_IRQ_FLAGS, 32'h07);
		wave_mode_lower_bits <= 2'h0;
		// asynchronous clocking and update busy bits
		bus_wr(IDX_ASYNC, 8'h40);
		check("crystal", crystal_osc_enable, 1'b0);
		check("buffer", osc_buffer_enable, 1'b0);
		bus_wr(IDX_ASYNC, 8'hE0);
		expect_rd("async", IDX_ASYNC, 32'h60);
		check("buffer", osc_buffer_enable, 1'b1);
		bus_wr(IDX_CMP_A, 8'h33);
		bus_wr(IDX_COUNTER, 8'h00);
		bus_wr(IDX_CTRL_B, 8'h00);
		control_a_write <= 1'b1;
		@(posedge aclk);
		control_a_write <= 1'b0;
		expect_rd("async", IDX_ASYNC, 32'h7B);
		timer_osc_pin <= 1'b1;
		repeat (8) @(posedge aclk);
		timer_osc_pin <= 1'b0;
		repeat (8) @(posedge aclk);
		expect_rd("async", IDX_ASYNC, 32'h60);
		expect_rd("compare a", IDX_CMP_A, 32'h33);
		wrap_up();
	end
endmodule : at8_timer_tb_top
